// >>> core/iep_defs.vh
// Constants for the pulse-counter/timer 9 enable and priority registers
`ifndef IEP_DEFS_VH
`define IEP_DEFS_VH

// Word indices on the bus (byte address = index * 4)
`define IEP_IDX_EN 4'h0
`define IEP_IDX_FLG 4'h1
`define IEP_IDX_PRI0 4'h2
`define IEP_IDX_PRI9 4'hB
`define IEP_IDX_STAT 4'hC
`define IEP_IDX_W 4
`define IEP_ADR_LO 2
`define IEP_ADR_HI 5
`define IEP_ADR_TOP_HI 7
`define IEP_ADR_TOP_LO 6

// Enable and request flag registers
`define IEP_EN_WMASK 8'h1F
`define IEP_EN_ONES 8'hE0
`define IEP_EN_RST 8'hE0
`define IEP_FLG_RST 8'hE0
`define IEP_OWN_W 5

// Priority registers: writable bits and bits forced to one
`define IEP_PRI_N 10
`define IEP_PRI0_WMASK 8'h0F
`define IEP_PRI1_WMASK 8'hF0
`define IEP_PRI2_WMASK 8'hFF
`define IEP_PRI3_WMASK 8'h3F
`define IEP_PRI4_WMASK 8'hFF
`define IEP_PRI5_WMASK 8'hF0
`define IEP_PRI6_WMASK 8'hFF
`define IEP_PRI7_WMASK 8'hCF
`define IEP_PRI8_WMASK 8'hFF
`define IEP_PRI9_WMASK 8'h03
`define IEP_PRI9_ONES 8'hFC
`define IEP_PRI_RST 8'h00
`define IEP_PRI9_RST 8'hFC

// Sources: 24 from outside, then 5 owned here
`define IEP_EXT_W 24
`define IEP_SRC_N 29
`define IEP_SRC_W 5
`define IEP_OWN_BASE 5'h18
`define IEP_LVL_W 2

// Status register layout
`define IEP_ST_REQ 7
`define IEP_ST_LVL_HI 6
`define IEP_ST_LVL_LO 5

`endif

// >>> core/iep_regs.v
// Pulse-counter/timer 9 enable, priority registers and priority arbiter
//
// Notes on behaviour
// - Enable bits 0..4 gate the four pulse counter events and timer 9.
// - Enable bits 7:5 ignore writes and always read as one.
// - Any of the five reset causes loads the enable register with E0.
// - Priority 0 holds external 0 and counter overflow, 7:4 read zero.
// - Priority 1 holds capture units 0 and 1, bits 3:0 read and write zero.
// - Priority 2 is a full 8-bit register for timer 0 and external 1..3.
// - Priority 3 holds timers 1..3 in bits 5:0, bits 7:6 read zero.
// - Priority 4 is a full 8-bit register for external 4..7.
// - Priority 5 holds timer 4 and serial 1 in 7:4, bits 3:0 read zero.
// - Priority 6 is a full 8-bit register for timer 5 and serial 4..6.
// - Priority 7 holds timer 6, converter, real-time counter; 5:4 zero.
// - Priority 8 is a full 8-bit register for the pulse counter events.
// - Priority 9 stores bits 1:0 only, reads one above, resets to FC.
// - Any reset cause clears priority registers 0..8 to 00.
// - Request flags set on the five events, read one in 7:5, reset E0.
`include "iep_defs.vh"
`default_nettype none

module iep_regs (
    // Clock and resets
    input wire ref_clk_i,
    input wire rst_i,
    input wire external_reset_pin_i,
    input wire break_instruction_i,
    input wire wdt_overflow_i,
    input wire opcode_trap_i,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Peripheral events and other pending requests
    input wire [4:0] pwm_timer9_event_i,
    input wire [23:0] ext_req_i,
    // Interrupt request to the core
    output wire irq_req_o,
    output wire [4:0] irq_src_o,
    output wire [1:0] irq_lvl_o,
    input wire irq_ack_i
);

    ////////////////////////////////////////////////////////////////////////
    function [7:0] pri_wmask;
        input [3:0] n;
        begin
            case (n)
                4'h0: pri_wmask = `IEP_PRI0_WMASK;
                4'h1: pri_wmask = `IEP_PRI1_WMASK;
                4'h2: pri_wmask = `IEP_PRI2_WMASK;
                4'h3: pri_wmask = `IEP_PRI3_WMASK;
                4'h4: pri_wmask = `IEP_PRI4_WMASK;
                4'h5: pri_wmask = `IEP_PRI5_WMASK;
                4'h6: pri_wmask = `IEP_PRI6_WMASK;
                4'h7: pri_wmask = `IEP_PRI7_WMASK;
                4'h8: pri_wmask = `IEP_PRI8_WMASK;
                default: pri_wmask = `IEP_PRI9_WMASK;
            endcase
        end
    endfunction

    function [7:0] pri_ones;
        input [3:0] n;
        begin
            pri_ones = (n == 4'h9) ? `IEP_PRI9_ONES : 8'h00;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Any reset cause restarts every register except the bus ack and read data, which only rst_i clears
    wire any_rst = rst_i | external_reset_pin_i | break_instruction_i |
                   wdt_overflow_i | opcode_trap_i;

    wire [3:0] idx = wb_adr_i[`IEP_ADR_HI:`IEP_ADR_LO];
    wire top_ok = (wb_adr_i[`IEP_ADR_TOP_HI:`IEP_ADR_TOP_LO] == 2'h0);
    wire req = wb_cyc_i & wb_stb_i;
    reg ack_r;
    // Write commits on the edge that raises ack; lane 0 only
    wire wr = req & ~ack_r & wb_we_i & wb_sel_i[0] & top_ok;

    reg [4:0] en_r;
    reg [4:0] flg_r;
    reg [7:0] pri_r [0:`IEP_PRI_N-1];
    reg irq_req_r;
    reg [4:0] irq_src_r;
    reg [1:0] irq_lvl_r;
    reg [7:0] rd_r;
    // Only the low five bits of the reset words are stored
    localparam [7:0] EN_RST = `IEP_EN_RST;
    localparam [7:0] FLG_RST = `IEP_FLG_RST;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk_i) begin
        if (any_rst) begin
            en_r <= EN_RST[`IEP_OWN_W-1:0];
        end else if (wr && idx == `IEP_IDX_EN) begin
            en_r <= wb_dat_i[4:0];
        end
    end

    // Ack clears the flag of the owned source being served; set wins
    wire ack_own = irq_ack_i & irq_req_r & (irq_src_r >= `IEP_OWN_BASE);
    wire [4:0] ack_clr =
        ack_own ? (5'h01 << (irq_src_r - `IEP_OWN_BASE)) : 5'h00;

    always @(posedge ref_clk_i) begin
        if (any_rst) begin
            flg_r <= FLG_RST[`IEP_OWN_W-1:0];
        end else if (wr && idx == `IEP_IDX_FLG) begin
            flg_r <= wb_dat_i[4:0] | pwm_timer9_event_i;
        end else begin
            flg_r <= (flg_r & ~ack_clr) | pwm_timer9_event_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `IEP_PRI_N; g = g + 1) begin : g_pri
            localparam [3:0] N = g;
            // Only the last register resets with its fixed ones
            localparam [7:0] RST_V = (N == `IEP_IDX_PRI9 - `IEP_IDX_PRI0) ?
                `IEP_PRI9_RST : `IEP_PRI_RST;
            always @(posedge ref_clk_i) begin
                if (any_rst) begin
                    pri_r[g] <= RST_V;
                end else if (wr && idx == N + `IEP_IDX_PRI0) begin
                    // Reserved bits are not stored, so they read fixed
                    pri_r[g] <= (wb_dat_i[7:0] & pri_wmask(N)) | pri_ones(N);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Arbiter over 29 sources, two level bits each
    wire [4:0] own_pend = flg_r & en_r;
    wire [`IEP_SRC_N-1:0] pend = {own_pend, ext_req_i};
    wire [2*`IEP_SRC_N-1:0] lvl_all = {
        pri_r[9][1:0], pri_r[8], pri_r[7][7:6], pri_r[7][3:0], pri_r[6],
        pri_r[5][7:4], pri_r[4], pri_r[3][5:0], pri_r[2], pri_r[1][7:4],
        pri_r[0][3:0]};

    reg found;
    reg [4:0] best_src;
    reg [1:0] best_lvl;
    integer i;
    always @* begin
        found = 1'b0;
        best_src = 5'h00;
        best_lvl = 2'h0;
        // Downward scan with >= lets the lowest index win a tie
        for (i = `IEP_SRC_N - 1; i >= 0; i = i - 1) begin
            if (pend[i] && (!found || lvl_all[2*i +: 2] >= best_lvl)) begin
                found = 1'b1;
                best_src = i[4:0];
                best_lvl = lvl_all[2*i +: 2];
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (any_rst) begin
            irq_req_r <= 1'b0;
            irq_src_r <= 5'h00;
            irq_lvl_r <= 2'h0;
        end else begin
            irq_req_r <= found;
            irq_src_r <= best_src;
            irq_lvl_r <= best_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus read mux and ack, one wait state
    reg [7:0] rd_nxt;
    always @* begin
        rd_nxt = 8'h00;
        if (top_ok) begin
            if (idx == `IEP_IDX_EN)
                rd_nxt = {3'h0, en_r} | `IEP_EN_ONES;
            else if (idx == `IEP_IDX_FLG)
                rd_nxt = {3'h0, flg_r} | `IEP_EN_ONES;
            else if (idx >= `IEP_IDX_PRI0 && idx <= `IEP_IDX_PRI9)
                rd_nxt = pri_r[idx - `IEP_IDX_PRI0];
            else if (idx == `IEP_IDX_STAT)
                rd_nxt = {irq_req_r, irq_lvl_r, irq_src_r};
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rd_r <= 8'h00;
        end else begin
            ack_r <= req & ~ack_r;
            if (req && !ack_r)
                rd_r <= rd_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, rd_r};
    assign irq_req_o = irq_req_r;
    assign irq_src_o = irq_src_r;
    assign irq_lvl_o = irq_lvl_r;

endmodule // iep_regs
`default_nettype wire

// >>> bench/iep_sva.sv
// Checker for the bus answer, read masks and interrupt reset
`default_nettype none
module iep_sva (
    // Clock and resets
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic external_reset_pin_i,
    // Bus and interrupt
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Read data is only meaningful with ack and a held read request
    wire rd = wb_ack_o && !wb_we_i;
    ack_next_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_single_a: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("long ack");
    en_ones_a: assert property (
        rd && wb_adr_i == 8'h00 |-> wb_dat_o[7:5] == 3'h7) else $error("en");
    pri0_zero_a: assert property (
        rd && wb_adr_i == 8'h08 |-> wb_dat_o[7:4] == 4'h0) else $error("p0");
    pri1_zero_a: assert property (
        rd && wb_adr_i == 8'h0C |-> wb_dat_o[3:0] == 4'h0) else $error("p1");
    pri5_zero_a: assert property (
        rd && wb_adr_i == 8'h1C |-> wb_dat_o[3:0] == 4'h0) else $error("p5");
    pri9_ones_a: assert property (
        rd && wb_adr_i == 8'h2C |-> wb_dat_o[7:2] == 6'h3F) else $error("p9");
    irq_clear_a: assert property (
        external_reset_pin_i |=> !irq_req_o) else $error("irq kept");
    cover property (rd && wb_adr_i == 8'h2C);
    cover property (irq_req_o);
    cover property (external_reset_pin_i);
endmodule // iep_sva
bind iep_regs iep_sva u_sva (.ref_clk_i, .rst_i, .external_reset_pin_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .irq_req_o);
`default_nettype wire

// >>> bench/iep_cpu_model.sv
// Core-side model that acknowledges owned interrupt requests
`default_nettype none
module iep_cpu_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Interrupt side
    input wire logic irq_req_i,
    input wire logic [4:0] irq_src_i,
    input wire logic [3:0] dly_i,
    output logic irq_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    initial irq_ack_o = 1'b0;
    // Only owned sources clear here; the others clear at their origin
    always @(posedge clk_i) begin
        irq_ack_o <= 1'b0;
        if (rst_i || !irq_req_i || irq_src_i < 5'h18) begin
            cnt <= 0;
        end else if (cnt == dly_i) begin
            irq_ack_o <= 1'b1;
            cnt <= -3;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // iep_cpu_model
`default_nettype wire

// >>> bench/iep_regs_tb.sv
// Testbench for the enable and priority registers
`default_nettype none
module iep_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, req, iak;
    logic [3:0] cause = 0, dly = 0, sel = 4'hF;
    logic [4:0] ev = 0, src;
    logic [1:0] lvl;
    logic [7:0] adr = 0;
    logic [23:0] ext = 0;
    logic [31:0] dw = 0, dr, rdat, d;
    logic [7:0] mdl [13];
    logic [7:0] wm [13] = '{8'h1F, 8'h1F, 8'h0F, 8'hF0, 8'hFF, 8'h3F,
        8'hFF, 8'hF0, 8'hFF, 8'hCF, 8'hFF, 8'h03, 8'h00};
    logic [7:0] on [13] = '{8'hE0, 8'hE0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'hFC, 0};
    int n_errors = 0, num_checks = 0, cyc_cnt = 0;
    iep_regs i_dut (.ref_clk_i(clk), .rst_i(rst),
        .external_reset_pin_i(cause[0]),
        .break_instruction_i(cause[1]), .wdt_overflow_i(cause[2]),
        .opcode_trap_i(cause[3]), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .pwm_timer9_event_i(ev), .ext_req_i(ext),
        .irq_req_o(req), .irq_src_o(src), .irq_lvl_o(lvl), .irq_ack_i(iak));
    iep_cpu_model i_cpu (.clk_i(clk), .rst_i(rst), .irq_req_i(req),
        .irq_src_i(src), .dly_i(dly), .irq_ack_o(iak));
    initial forever #50 clk = ~clk;
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) if (++cyc_cnt == 3000) begin
        n_errors++;
        summarize();
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // Request held until ack is sampled high, then released for a cycle
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] v, input logic [3:0] s = 4'hF);
        cyc <= 1;
        stb <= 1;
        we <= w;
        sel <= s;
        adr <= a;
        dw <= v;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dr;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task automatic rdall;
        for (int i = 0; i < 13; i++) begin
            bus(0, 8'(i * 4), 0);
            chk($sformatf("reg%0d", i), {24'h0, mdl[i]}, rdat);
        end
    endtask
    task automatic wsrc(input logic [4:0] v, input logic [1:0] l);
        for (int t = 0; t < 40 && src !== v; t++) @(posedge clk);
        chk("src", v, src);
        chk("lvl", l, lvl);
        chk("req", 1, req);
    endtask
    initial begin
        void'($urandom(95));
        mdl = on;
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int r = 0; r < 4; r++) begin
            dly <= 4'($urandom);
            rdall();
            for (int i = 0; i < 12; i++) begin
                d = $urandom;
                if (i == 1) d = d & ~mdl[0];
                if (i > 1 && i < 11) d = d & wm[i];
                bus(1, 8'(i * 4), d);
                mdl[i] = (d[7:0] & wm[i]) | on[i];
            end
            bus(1, 8'h40, 32'h1F);
            // Lane 0 not selected: acked but must not land
            bus(1, 8'h00, 32'h1F, 4'hE);
            bus(0, 8'hC0, 0);
            chk("unmapped", 0, rdat);
            rdall();
            cause[r] <= 1;
            @(posedge clk);
            cause <= 0;
            mdl = on;
            $display("round %0d done", r);
        end
        rdall();
        bus(1, 8'h2C, 3);
        bus(1, 8'h08, 2);
        ev[4] <= 1;
        @(posedge clk);
        ev <= 0;
        repeat (4) @(posedge clk);
        chk("idle", 0, req);
        ext <= 24'h1;
        bus(1, 8'h00, 32'h10);
        wsrc(5'd28, 2'd3);
        wsrc(5'd0, 2'd2);
        bus(0, 8'h30, 0);
        chk("status", 32'hC0, rdat);
        bus(0, 8'h04, 0);
        chk("flags", 32'hE0, rdat);
        // Equal levels: external source 0 must beat owned source 24
        bus(1, 8'h28, 2);
        bus(1, 8'h00, 32'h11);
        ev[0] <= 1;
        @(posedge clk);
        ev <= 0;
        repeat (3) @(posedge clk);
        chk("tie", 0, src);
        ext <= 0;
        wsrc(5'd24, 2'd2);
        // Reset while a request stands must drop it and restore the map
        ext <= 24'h1;
        repeat (3) @(posedge clk);
        chk("pending", 1, req);
        cause[0] <= 1;
        @(posedge clk);
        cause <= 0;
        ext <= 0;
        mdl = on;
        rdall();
        chk("cleared", 0, req);
        $display("interrupt test done");
        summarize();
    end
endmodule // iep_regs_tb
`default_nettype wire
